// ---- hdl/fxref_ctrl.sv ----
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fxref_ctrl
  import fxref_pkg::*;
#(
  parameter int   STAB_CYCLES  = FXREF_STAB_CYCLES,
  parameter logic ALWAYS_READY = 1'b0
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  output var  logic        o_enable,
  output var  logic        o_ready,
  output var  logic [2:0]  o_adc_gain,
  output var  logic [2:0]  o_sense_gain,
  output var  logic        o_irq
);

  localparam int CW = $clog2(STAB_CYCLES + 1);
  localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES);
  localparam logic [CW-1:0] CNT_ZERO  = '0;
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);

  logic                  en_ff;
  logic                  nxt_en;
  logic [1:0]            adc_sel_ff;
  logic [1:0]            sense_sel_ff;
  logic                  ready_ff;
  logic                  nxt_ready;
  fxref_state_e          state_ff;
  fxref_state_e          nxt_state;
  logic [CW-1:0]         cnt_ff;
  logic [FXREF_EV_W-1:0] stat_ff;
  logic [FXREF_EV_W-1:0] mask_ff;
  logic [FXREF_EV_W-1:0] ev_set;
  logic                  access;
  logic                  wr_done;
  logic                  hit_ctrl;
  logic                  hit_stat;
  logic                  hit_mask;
  logic                  mapped;
  logic [31:0]           rd_val;

  // Bus decode; a write lands on the edge that completes it
  assign access   = i_psel && i_penable;
  assign wr_done  = access && o_pready && i_pwrite && !o_pslverr;
  assign hit_ctrl = (i_paddr == FXREF_CTRL_OFFS);
  assign hit_stat = (i_paddr == FXREF_STAT_OFFS);
  assign hit_mask = (i_paddr == FXREF_MASK_OFFS);
  assign mapped   = hit_ctrl || hit_stat || hit_mask;

  // Read mux; reserved bits and upper bits return zero
  always_comb begin
    rd_val = FXREF_RDATA_RST;
    if (hit_ctrl) begin
      rd_val[FXREF_READY_BIT]                  = ready_ff;
      rd_val[FXREF_ENABLE_BIT]                 = en_ff;
      rd_val[FXREF_RSVD_HI:FXREF_RSVD_LO]      = 2'h0;
      rd_val[FXREF_SENSE_HI:FXREF_SENSE_LO]    = sense_sel_ff;
      rd_val[FXREF_ADC_HI:FXREF_ADC_LO]        = adc_sel_ff;
    end else if (hit_stat) begin
      rd_val[FXREF_EV_W-1:0] = stat_ff;
    end else if (hit_mask) begin
      rd_val[FXREF_EV_W-1:0] = mask_ff;
    end
  end

  // APB answer: pready one cycle into the access phase
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= FXREF_RDATA_RST;
    end else if (access && !o_pready) begin
      o_pready  <= 1'b1;
      o_pslverr <= !mapped;
      o_prdata  <= i_pwrite ? FXREF_RDATA_RST : rd_val;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= FXREF_RDATA_RST;
    end
  end

  // Next enable from a completed control write
  assign nxt_en = (wr_done && hit_ctrl) ? i_pwdata[FXREF_ENABLE_BIT] : en_ff;

  // Control register; reserved bits are not stored
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_ff        <= FXREF_EN_RST;
      adc_sel_ff   <= FXREF_GAIN_RST;
      sense_sel_ff <= FXREF_GAIN_RST;
    end else begin
      en_ff <= nxt_en;
      if (wr_done && hit_ctrl) begin
        adc_sel_ff   <= i_pwdata[FXREF_ADC_HI:FXREF_ADC_LO];
        sense_sel_ff <= i_pwdata[FXREF_SENSE_HI:FXREF_SENSE_LO];
      end
    end
  end

  // Settling sequence after enable
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FXREF_ST_OFF: begin
        if (nxt_en) begin
          nxt_state = FXREF_ST_SETTLE;
        end
      end
      FXREF_ST_SETTLE: begin
        if (!nxt_en) begin
          nxt_state = FXREF_ST_OFF;
        end else if (cnt_ff == STAB_LAST - CNT_ONE) begin
          nxt_state = FXREF_ST_READY;
        end
      end
      FXREF_ST_READY: begin
        if (!nxt_en) begin
          nxt_state = FXREF_ST_OFF;
        end
      end
      default: nxt_state = FXREF_ST_OFF;
    endcase
  end

  // Ready flag follows state; fixed high on the standard variant
  assign nxt_ready = ALWAYS_READY || (nxt_state == FXREF_ST_READY);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= FXREF_ST_OFF;
      cnt_ff   <= CNT_ZERO;
      ready_ff <= ALWAYS_READY;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      if (state_ff == FXREF_ST_SETTLE && nxt_state == FXREF_ST_SETTLE) begin
        cnt_ff <= cnt_ff + CNT_ONE;
      end else begin
        cnt_ff <= CNT_ZERO;
      end
    end
  end

  // Events: reference became ready, or ready was lost
  assign ev_set[FXREF_EV_READY_BIT] = nxt_ready && !ready_ff;
  assign ev_set[FXREF_EV_LOST_BIT]  = ready_ff && !nxt_ready;

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_ff <= FXREF_EV_RST;
      mask_ff <= FXREF_EV_RST;
    end else begin
      if (wr_done && hit_stat) begin
        stat_ff <= (stat_ff & ~i_pwdata[FXREF_EV_W-1:0]) | ev_set;
      end else begin
        stat_ff <= stat_ff | ev_set;
      end
      if (wr_done && hit_mask) begin
        mask_ff <= i_pwdata[FXREF_EV_W-1:0];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq    <= 1'b0;
      o_enable <= FXREF_EN_RST;
      o_ready  <= ALWAYS_READY;
    end else begin
      o_irq    <= |(stat_ff & mask_ff);
      o_enable <= en_ff;
      o_ready  <= ready_ff;
    end
  end

  // Independent gain stages for the two consumers
  fxref_gain_stage u_adc_stage (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_enable  (en_ff),
    .i_sel     (adc_sel_ff),
    .o_gain    (o_adc_gain)
  );

  fxref_gain_stage u_sense_stage (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_enable  (en_ff),
    .i_sel     (sense_sel_ff),
    .o_gain    (o_sense_gain)
  );

  // Checks
  logic [CW:0] en_age_ff;

  // Cycles since enable rose, saturating
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_age_ff <= '0;
    end else if (!en_ff) begin
      en_age_ff <= '0;
    end else if (en_age_ff <= (CW+1)'(STAB_CYCLES)) begin
      en_age_ff <= en_age_ff + (CW+1)'(1);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  AST_EN_WRITE: assert property (
    wr_done && hit_ctrl |=> en_ff == $past(i_pwdata[FXREF_ENABLE_BIT])
  ) else $error("enable bit did not follow control write");

  AST_READY_NOT_EARLY: assert property (
    !ALWAYS_READY && ready_ff |-> en_age_ff >= (CW+1)'(STAB_CYCLES)
  ) else $error("ready set before stabilisation time");

  AST_READY_ON_TIME: assert property (
    !ALWAYS_READY && en_ff && en_age_ff == (CW+1)'(STAB_CYCLES) |-> ready_ff
  ) else $error("ready late after stabilisation time");

  AST_READY_OFF: assert property (
    !ALWAYS_READY && !en_ff |-> !ready_ff ##1 !o_ready
  ) else $error("ready high while reference disabled");

  AST_READY_SETTLING: assert property (
    !ALWAYS_READY && state_ff == FXREF_ST_SETTLE |-> !ready_ff && !o_ready
  ) else $error("ready high while reference settling");

  AST_ADC_X2: assert property (
    en_ff && adc_sel_ff == FXREF_SEL_X2 |=> o_adc_gain == FXREF_GAIN_X2
  ) else $error("adc gain 2x decode wrong");

  AST_SENSE_X4: assert property (
    en_ff && sense_sel_ff == FXREF_SEL_X4 |=> o_sense_gain == FXREF_GAIN_X4
  ) else $error("sense gain 4x decode wrong");

  AST_ADC_X1: assert property (
    en_ff && adc_sel_ff == FXREF_SEL_X1 |=> o_adc_gain == FXREF_GAIN_X1
  ) else $error("adc gain 1x decode wrong");

  AST_SENSE_OFF: assert property (
    en_ff && sense_sel_ff == FXREF_SEL_OFF |=> o_sense_gain == FXREF_GAIN_OFF
  ) else $error("sense gain off decode wrong");

  AST_STAGES_INDEP: assert property (
    en_ff && adc_sel_ff == FXREF_SEL_OFF && sense_sel_ff == FXREF_SEL_X1
    |=> o_adc_gain == FXREF_GAIN_OFF && o_sense_gain == FXREF_GAIN_X1
  ) else $error("gain stages not independent");

  AST_RSVD_ZERO: assert property (
    access && !o_pready && hit_ctrl && !i_pwrite
    |=> o_prdata[FXREF_RSVD_HI:FXREF_RSVD_LO] == 2'h0
  ) else $error("reserved bits read nonzero");

  AST_ALWAYS_READY: assert property (
    ALWAYS_READY |-> ready_ff && o_ready
  ) else $error("standard variant ready not high");

  AST_DISABLE_OUTS: assert property (
    !en_ff |=> o_adc_gain == FXREF_GAIN_OFF && o_sense_gain == FXREF_GAIN_OFF
  ) else $error("gain outputs active while disabled");

  AST_IRQ_LEVEL: assert property (
    |(stat_ff & mask_ff) |=> o_irq
  ) else $error("interrupt not raised for unmasked status");

  AST_IRQ_CLEAR: assert property (
    !(|(stat_ff & mask_ff)) |=> !o_irq
  ) else $error("interrupt high with no unmasked status");

  AST_STAT_SET_WINS: assert property (
    |ev_set |=> (stat_ff & $past(ev_set)) == $past(ev_set)
  ) else $error("status event lost");

  AST_PREADY_PULSE: assert property (
    o_pready |=> !o_pready
  ) else $error("pready held longer than one cycle");

  AST_SLVERR_MAP: assert property (
    access && !o_pready |=> o_pready && o_pslverr == !$past(mapped)
  ) else $error("bus answer or error flag wrong");

  CV_READY_REACHED: cover property ($rose(ready_ff));
  CV_ABORT_SETTLE: cover property (state_ff == FXREF_ST_SETTLE ##1 state_ff == FXREF_ST_OFF);
  CV_UNMAPPED: cover property (o_pready && o_pslverr);
  CV_IRQ: cover property ($rose(o_irq));

endmodule
`default_nettype wire

// ---- include/fxref_pkg.sv ----
`default_nettype none
package fxref_pkg;

  // Register byte offsets
  localparam logic [7:0] FXREF_CTRL_OFFS   = 8'h00;
  localparam logic [7:0] FXREF_STAT_OFFS   = 8'h04;
  localparam logic [7:0] FXREF_MASK_OFFS   = 8'h08;

  // Control register field positions
  localparam int FXREF_READY_BIT   = 7;
  localparam int FXREF_ENABLE_BIT  = 6;
  localparam int FXREF_RSVD_HI     = 5;
  localparam int FXREF_RSVD_LO     = 4;
  localparam int FXREF_SENSE_HI    = 3;
  localparam int FXREF_SENSE_LO    = 2;
  localparam int FXREF_ADC_HI      = 1;
  localparam int FXREF_ADC_LO      = 0;

  // Interrupt status and mask field positions
  localparam int FXREF_EV_READY_BIT = 0;
  localparam int FXREF_EV_LOST_BIT  = 1;
  localparam int FXREF_EV_W         = 2;

  // Reset values
  localparam logic [1:0]  FXREF_GAIN_RST  = 2'h0;
  localparam logic        FXREF_EN_RST    = 1'b0;
  localparam logic [1:0]  FXREF_EV_RST    = 2'h0;
  localparam logic [31:0] FXREF_RDATA_RST = 32'h0000_0000;

  // Gain select codes and decoded one-hot gains
  localparam logic [1:0] FXREF_SEL_OFF = 2'h0;
  localparam logic [1:0] FXREF_SEL_X1  = 2'h1;
  localparam logic [1:0] FXREF_SEL_X2  = 2'h2;
  localparam logic [1:0] FXREF_SEL_X4  = 2'h3;
  localparam logic [2:0] FXREF_GAIN_OFF = 3'h0;
  localparam logic [2:0] FXREF_GAIN_X1  = 3'h1;
  localparam logic [2:0] FXREF_GAIN_X2  = 3'h2;
  localparam logic [2:0] FXREF_GAIN_X4  = 3'h4;

  // Stabilisation timing
  localparam int FXREF_CLK_MHZ      = 200;
  localparam int FXREF_STAB_TIME_NS = 10000;
  localparam int FXREF_STAB_CYCLES  =
    (FXREF_STAB_TIME_NS * FXREF_CLK_MHZ + 999) / 1000;

  // Reference sequencing states
  typedef enum logic [1:0] {
    FXREF_ST_OFF    = 2'b00,
    FXREF_ST_SETTLE = 2'b01,
    FXREF_ST_READY  = 2'b10
  } fxref_state_e;

endpackage
`default_nettype wire

// ---- hdl/fxref_gain_stage.sv ----
`timescale 1ns/1ps
`default_nettype none
module fxref_gain_stage
  import fxref_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_enable,
  input  wire logic [1:0] i_sel,
  output var  logic [2:0] o_gain
);

  logic [2:0] nxt_gain;

  // Decode select into one-hot gain, off when disabled
  always_comb begin
    nxt_gain = FXREF_GAIN_OFF;
    if (i_enable) begin
      unique case (i_sel)
        FXREF_SEL_OFF: nxt_gain = FXREF_GAIN_OFF;
        FXREF_SEL_X1:  nxt_gain = FXREF_GAIN_X1;
        FXREF_SEL_X2:  nxt_gain = FXREF_GAIN_X2;
        FXREF_SEL_X4:  nxt_gain = FXREF_GAIN_X4;
      endcase
    end
  end

  // Registered gain output
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gain <= FXREF_GAIN_OFF;
    end else begin
      o_gain <= nxt_gain;
    end
  end

endmodule
`default_nettype wire

// ---- tb/fxref_consumer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fxref_consumer_model (
  input  wire logic        i_enable,
  input  wire logic [2:0]  i_adc_gain,
  input  wire logic [2:0]  i_sense_gain,
  output var  logic [12:0] o_adc_mv,
  output var  logic [12:0] o_sense_mv
);
  // Level each consumer sees, in mV; a one-hot gain scales 1024
  always_comb begin
    o_adc_mv   = i_enable ? 13'(i_adc_gain) * 13'h400 : 13'h0;
    o_sense_mv = i_enable ? 13'(i_sense_gain) * 13'h400 : 13'h0;
  end
endmodule
`default_nettype wire

// ---- tb/fxref_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fxref_ctrl_tb;
  import fxref_pkg::*;
  localparam int STAB_T = 8;
  logic        i_clk, i_reset_n, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_enable, o_ready, o_irq, std_ready, err;
  logic [2:0]  o_adc_gain, o_sense_gain;
  logic [12:0] adc_mv, sense_mv;
  int          fail_count = 0;
  int          checks_done = 0;
  int          n;

  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

  // Block under test, short settling count
  fxref_ctrl #(.STAB_CYCLES(STAB_T), .ALWAYS_READY(1'b0)) u_fxref_ctrl (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_enable(o_enable), .o_ready(o_ready),
    .o_adc_gain(o_adc_gain), .o_sense_gain(o_sense_gain), .o_irq(o_irq));
  // Standard-voltage variant, only its ready flag is watched
  fxref_ctrl #(.STAB_CYCLES(STAB_T), .ALWAYS_READY(1'b1)) u_fxref_ctrl_std (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(),
    .o_pready(), .o_pslverr(), .o_enable(), .o_ready(std_ready),
    .o_adc_gain(), .o_sense_gain(), .o_irq());
  // Analog consumers of the selected levels
  fxref_consumer_model u_fxref_consumer_model (
    .i_enable(o_enable), .i_adc_gain(o_adc_gain), .i_sense_gain(o_sense_gain),
    .o_adc_mv(adc_mv), .o_sense_mv(sense_mv));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic end_sim;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr_en;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (o_pready !== 1'b1) begin
      fail_count++;
      end_sim();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  function automatic logic [2:0] hot(input logic [1:0] s);
    return (s == 2'h0) ? 3'h0 : 3'h1 << (s - 2'h1);
  endfunction

  // Settling time, ready events, interrupt mask and clear
  task automatic t_ready_irq;
    wr(FXREF_MASK_OFFS, 32'h1);
    wr(FXREF_CTRL_OFFS, 32'h45);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_ready !== 1'b1 && n < 40);
    `CHK(n, STAB_T + 2)
    rchk(FXREF_CTRL_OFFS, 32'hC5);
    rchk(FXREF_STAT_OFFS, 32'h1);
    `CHK(o_irq, 1'b1)
    wr(FXREF_STAT_OFFS, 32'h1);
    rchk(FXREF_STAT_OFFS, 32'h0);
    `CHK(o_irq, 1'b0)
    wr(FXREF_CTRL_OFFS, 32'h05);
    rchk(FXREF_CTRL_OFFS, 32'h05);
    `CHK({o_enable, o_ready, o_adc_gain, o_sense_gain, o_irq}, 9'h0)
    rchk(FXREF_STAT_OFFS, 32'h2);
    wr(FXREF_MASK_OFFS, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'b1)
    wr(FXREF_STAT_OFFS, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'b0)
  endtask

  // Every gain pair, then a control readback and a disable
  task automatic t_gains;
    for (int i = 0; i < 16; i++) begin
      wr(FXREF_CTRL_OFFS, 32'h40 | 32'(i));
      repeat (2) @(posedge i_clk);
      `CHK(o_enable, 1'b1)
      `CHK(o_adc_gain, hot(i[1:0]))
      `CHK(o_sense_gain, hot(i[3:2]))
      `CHK(adc_mv, 13'(hot(i[1:0])) * 13'h400)
      `CHK(sense_mv, 13'(hot(i[3:2])) * 13'h400)
    end
    rchk(FXREF_CTRL_OFFS, 32'hCF);
    wr(FXREF_CTRL_OFFS, 32'h0F);
    rchk(FXREF_CTRL_OFFS, 32'h0F);
    `CHK({o_enable, o_adc_gain, o_sense_gain}, 7'h0)
  endtask

  // Unmapped address is refused, control left alone
  task automatic t_unmapped;
    wr(8'h0C, 32'hFF);
    `CHK(err, 1'b1)
    rchk(8'h0C, 32'h0);
    `CHK(err, 1'b1)
    rchk(FXREF_CTRL_OFFS, 32'h0F);
    `CHK(err, 1'b0)
  endtask

  // Reset in mid-run clears enable and gains
  task automatic t_mid_reset;
    wr(FXREF_CTRL_OFFS, 32'h4A);
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    `CHK({o_enable, o_ready, o_adc_gain, o_sense_gain}, 8'h0)
    `CHK(std_ready, 1'b1)
    rchk(FXREF_CTRL_OFFS, 32'h0);
  endtask

  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    i_psel    = 1'b0;
    i_penable = 1'b0;
    i_pwrite  = 1'b0;
    i_paddr   = 8'h00;
    i_pwdata  = 32'h0;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rchk(FXREF_CTRL_OFFS, 32'h0);
    rchk(FXREF_STAT_OFFS, 32'h0);
    rchk(FXREF_MASK_OFFS, 32'h0);
    `CHK(std_ready, 1'b1)
    t_ready_irq();
    `CHK(std_ready, 1'b1)
    t_gains();
    t_unmapped();
    t_mid_reset();
    end_sim();
  end
endmodule
`default_nettype wire
